// *** bench/section_crc_properties.sv ***
`timescale 1ns/1ps
module section_crc_properties (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // register bus
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    // fault flags
    input wire logic [2:0]  sectionCrcFaultN,
    input wire logic        digitalCombinedFaultN
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence wrTaken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence wrAnswer;
        !bvalid ##1 bvalid;
    endsequence
    // a flag may only return high around a write answer
    sequence nearWrite;
        bvalid || $past(bvalid);
    endsequence

    a_write_answer: assert property (wrTaken |=> wrAnswer)
        else $error("write response not two cycles after handshake");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data not one cycle after handshake");
    a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped before bready");
    a_rdata_hold: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed before rready");
    a_write_blocked: assert property (bvalid |-> !awready && !wready)
        else $error("write channel ready while response pending");
    a_read_blocked: assert property (rvalid |-> !arready)
        else $error("read address ready while data pending");
    a_resp_okay: assert property (
        bvalid |-> bresp == section_crc_pkg::AXI_OKAY)
        else $error("write response code not okay");
    a_rresp_okay: assert property (
        rvalid |-> rresp == section_crc_pkg::AXI_OKAY)
        else $error("read response code not okay");
    a_fault_clear_write: assert property (
        (|($past(~sectionCrcFaultN) & sectionCrcFaultN)) |-> nearWrite)
        else $error("section fault flag returned high without a write");
    a_comb_clear_guard: assert property (
        $rose(digitalCombinedFaultN) |-> $past(&sectionCrcFaultN) ##0 nearWrite)
        else $error("combined flag cleared while a detail flag was low");
    a_comb_fault_cause: assert property (
        $fell(digitalCombinedFaultN) |-> !(&sectionCrcFaultN))
        else $error("combined flag fell with no detail flag low");
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic        sys_clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [9:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid, irq, combN;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [2:0]  faultN;
    logic [15:0] mapWord [256];
    logic [15:0] crcC, crcA;
    int          fail_count, n_compared, n;
    // one check bit per diagnostic tick; bound adds a tick
    localparam int WAIT1 =
        (26 * 16 + 1) * int'(section_crc_pkg::DIAG_OSC_DIV) + 2;

    register_map_section_crc_monitor register_map_section_crc_monitor_inst (
        .sys_clk(sys_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .sectionCrcFaultN(faultN), .digitalCombinedFaultN(combN), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        int  k;
        logic aT, wT, bT, bS;
        k = 0;
        bT = 1'b0;
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // bready follows bvalid by a cycle so a stalled answer is seen
        while (!bT && k < 200) begin
            @(negedge sys_clk);
            aT = awvalid && awready;
            wT = wvalid && wready;
            bT = bvalid && bready;
            bS = bvalid;
            @(posedge sys_clk);
            if (aT) awvalid <= 1'b0;
            if (wT) wvalid <= 1'b0;
            bready <= bS && !bT;
            k++;
        end
        @(posedge sys_clk);
        if (!bT) begin
            fail_count++;
            finish_test();
        end
    endtask

    task automatic rdChk(input logic [7:0] idx, input logic [15:0] exp);
        int  k;
        logic aT, rT, rS;
        logic [31:0] got;
        k = 0;
        rT = 1'b0;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        // rready follows rvalid by a cycle so held read data is seen
        while (!rT && k < 200) begin
            @(negedge sys_clk);
            aT = arvalid && arready;
            rT = rvalid && rready;
            rS = rvalid;
            got = rdata;
            @(posedge sys_clk);
            if (aT) arvalid <= 1'b0;
            rready <= rS && !rT;
            k++;
        end
        @(posedge sys_clk);
        if (!rT) begin
            fail_count++;
            finish_test();
        end
        chk(got, {16'h0000, exp});
    endtask

    // flags and irq sampled mid-cycle, away from the launching edge
    task automatic outChk(input logic [2:0] f, input logic c, input logic i);
        @(negedge sys_clk);
        chk(32'({faultN, combN, irq}), 32'({f, c, i}));
        @(posedge sys_clk);
    endtask

    function automatic logic [15:0] crcOf(input int first, input int last,
                                          input logic [15:0] poly);
        logic [15:0] c;
        logic        fb;
        c = 16'hffff;
        for (int a = first; a <= last; a++) begin
            for (int b = 15; b >= 0; b--) begin
                fb = c[15] ^ mapWord[a][b];
                c = {c[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
            end
        end
        return c;
    endfunction

    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 10'h000;
        araddr = 10'h000;
        wdata = 32'h00000000;
        wstrb = 4'hf;
        fail_count = 0;
        n_compared = 0;
        foreach (mapWord[i]) mapWord[i] = 16'h0000;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        outChk(3'h7, 1'b1, 1'b0);
        rdChk(section_crc_pkg::IDX_CRC_CTRL, 16'h0000);
        rdChk(section_crc_pkg::IDX_DIG_STATUS, 16'h0007);
        rdChk(section_crc_pkg::IDX_COMB_STATUS, 16'h0001);
        rdChk(8'h30, 16'h0000);
        // asymmetric words at both ends expose a reversed stream
        mapWord[8'h40] = 16'ha5c3;
        mapWord[8'h59] = 16'h1234;
        mapWord[8'h80] = 16'h00ff;
        wr(8'h40, mapWord[8'h40]);
        wr(8'h59, mapWord[8'h59]);
        wr(8'h80, mapWord[8'h80]);
        wr(8'h5a, 16'hffff);
        rdChk(8'h59, 16'h1234);
        rdChk(8'h5a, 16'h0000);
        crcC = crcOf(8'h40, 8'h59, section_crc_pkg::CRC_POLY_CCITT);
        crcA = crcOf(8'h40, 8'h59, section_crc_pkg::CRC_POLY_ANSI);
        wr(section_crc_pkg::IDX_CRC_EXP1, crcC);
        wr(section_crc_pkg::IDX_CRC_EXP2,
           ~crcOf(8'h80, 8'ha3, section_crc_pkg::CRC_POLY_CCITT));
        wr(section_crc_pkg::IDX_CRC_EXP3,
           ~crcOf(8'hc0, 8'he3, section_crc_pkg::CRC_POLY_CCITT));
        wr(section_crc_pkg::IDX_CRC_CTRL, 16'h0003);
        n = 0;
        while (faultN[1] !== 1'b0 && n < 40000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 40000) begin
            fail_count++;
            finish_test();
        end
        // section one has passed once by now; section three stays off
        outChk(3'h5, 1'b0, 1'b0);
        rdChk(section_crc_pkg::IDX_INT_STATUS, 16'h0002);
        wr(section_crc_pkg::IDX_INT_MASK, 16'h0002);
        outChk(3'h5, 1'b0, 1'b1);
        wr(section_crc_pkg::IDX_CRC_CTRL, 16'h0000);
        wr(section_crc_pkg::IDX_COMB_STATUS, 16'h0001);
        rdChk(section_crc_pkg::IDX_COMB_STATUS, 16'h0000);
        wr(section_crc_pkg::IDX_DIG_STATUS, 16'h0002);
        rdChk(section_crc_pkg::IDX_DIG_STATUS, 16'h0007);
        wr(section_crc_pkg::IDX_COMB_STATUS, 16'h0001);
        rdChk(section_crc_pkg::IDX_COMB_STATUS, 16'h0001);
        wr(section_crc_pkg::IDX_INT_STATUS, 16'h0002);
        outChk(3'h7, 1'b1, 1'b0);
        rdChk(8'h40, 16'ha5c3);
        // fresh pass under the other polynomial, then a live edit that
        // lands before the pass reaches the edited word
        wr(section_crc_pkg::IDX_CRC_EXP1, crcA);
        wr(section_crc_pkg::IDX_CRC_CTRL, 16'h0009);
        mapWord[8'h41] = 16'h5a0f;
        wr(8'h41, mapWord[8'h41]);
        crcA = crcOf(8'h40, 8'h59, section_crc_pkg::CRC_POLY_ANSI);
        wr(section_crc_pkg::IDX_CRC_EXP1, crcA);
        repeat (WAIT1) @(posedge sys_clk);
        outChk(3'h7, 1'b1, 1'b0);
        wr(section_crc_pkg::IDX_DIG_STATUS, 16'h0007);
        outChk(3'h7, 1'b1, 1'b0);
        finish_test();
    end
endmodule

bind register_map_section_crc_monitor section_crc_properties
    section_crc_properties_inst (
    .sys_clk, .rst, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
    .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sectionCrcFaultN, .digitalCombinedFaultN);

// *** include/section_crc_pkg.sv ***
package section_crc_pkg;

    // register index (byte address is four times the index)
    localparam logic [7:0] IDX_CRC_CTRL    = 8'h10;
    localparam logic [7:0] IDX_CRC_EXP1    = 8'h11;
    localparam logic [7:0] IDX_CRC_EXP2    = 8'h12;
    localparam logic [7:0] IDX_CRC_EXP3    = 8'h13;
    localparam logic [7:0] IDX_DIG_STATUS  = 8'h14;
    localparam logic [7:0] IDX_COMB_STATUS = 8'h15;
    localparam logic [7:0] IDX_DIG_MASK    = 8'h16;
    localparam logic [7:0] IDX_INT_STATUS  = 8'h17;
    localparam logic [7:0] IDX_INT_MASK    = 8'h18;

    // field positions
    localparam int CTRL_EN_LSB    = 0;
    localparam int CTRL_POLY_BIT  = 3;
    localparam int FAULT_LSB      = 0;
    localparam int COMB_FAULT_BIT = 0;

    // reset values
    localparam logic [2:0]  RST_ENABLE   = 3'h0;
    localparam logic        RST_POLY     = 1'h0;
    localparam logic [15:0] RST_EXPECTED = 16'h0000;
    localparam logic [2:0]  RST_FAULT_N  = 3'h7;
    localparam logic        RST_COMB_N   = 1'h1;
    localparam logic [2:0]  RST_MASK     = 3'h0;
    localparam logic [2:0]  RST_INT      = 3'h0;
    localparam logic [15:0] RST_MAP_WORD = 16'h0000;

    // crc engine
    localparam logic [15:0] CRC_SEED       = 16'hffff;
    localparam logic [15:0] CRC_POLY_CCITT = 16'h1021;
    localparam logic [15:0] CRC_POLY_ANSI  = 16'h8005;
    localparam logic [3:0]  MSB_BIT        = 4'hf;
    localparam logic [3:0]  LSB_BIT        = 4'h0;

    // covered register ranges, element 0 is section one
    localparam logic [2:0][7:0] SEC_FIRST = {8'hc0, 8'h80, 8'h40};
    localparam logic [2:0][7:0] SEC_LAST  = {8'he3, 8'ha3, 8'h59};
    localparam int NUM_SECTIONS = 3;

    // diagnostic oscillator period in system clocks
    localparam logic [7:0] DIAG_OSC_DIV = 8'h40;

    // axi answers
    localparam logic [1:0] AXI_OKAY = 2'h0;

endpackage

// *** logic/register_map_section_crc_monitor.sv ***
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module register_map_section_crc_monitor (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // axi4-lite write address
    input  wire logic [9:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // axi4-lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi4-lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read address
    input  wire logic [9:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // axi4-lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // fault flags and interrupt
    output logic [2:0]       sectionCrcFaultN,
    output logic             digitalCombinedFaultN,
    output logic             irq
);

    // axi slave state
    logic        awFull_r,  awFull_nxt;
    logic        wFull_r,   wFull_nxt;
    logic        awReady_r, awReady_nxt;
    logic        wReady_r,  wReady_nxt;
    logic        bvalid_r,  bvalid_nxt;
    logic        arReady_r, arReady_nxt;
    logic        rvalid_r,  rvalid_nxt;
    logic [7:0]  wrIdx_r,   wrIdx_nxt;
    logic [15:0] wrData_r,  wrData_nxt;
    logic [1:0]  wrStrb_r,  wrStrb_nxt;
    logic [31:0] rdata_r,   rdata_nxt;
    logic        doWrite;

    // register file
    logic [15:0] mapMem_r [256];
    logic [15:0] mapMem_nxt [256];
    logic [2:0]  enable_r,   enable_nxt;
    logic        polySel_r,  polySel_nxt;
    logic [2:0][15:0] expected_r, expected_nxt;
    logic [2:0]  faultN_r,   faultN_nxt;
    logic        combN_r,    combN_nxt;
    logic [2:0]  mask_r,     mask_nxt;
    logic [2:0]  intStat_r,  intStat_nxt;
    logic [2:0]  intMask_r,  intMask_nxt;
    logic        irq_r,      irq_nxt;

    // diagnostic oscillator divider
    logic [7:0]  divCnt_r,   divCnt_nxt;
    logic        tick_r,     tick_nxt;

    // crc engines
    logic [2:0][7:0]  ptr_r,  ptr_nxt;
    logic [2:0][3:0]  bit_r,  bit_nxt;
    logic [2:0][15:0] crc_r,  crc_nxt;
    logic [2:0]       mismatch;
    logic [15:0]      poly;

    function automatic logic inSection(input logic [7:0] idx);
        logic hit;
        hit = 1'b0;
        for (int s = 0; s < section_crc_pkg::NUM_SECTIONS; s++) begin
            if (idx >= section_crc_pkg::SEC_FIRST[s] &&
                idx <= section_crc_pkg::SEC_LAST[s]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    function automatic logic [15:0] strobed(input logic [15:0] old,
                                            input logic [15:0] val,
                                            input logic [1:0]  strb);
        return {strb[1] ? val[15:8] : old[15:8],
                strb[0] ? val[7:0]  : old[7:0]};
    endfunction

    assign awready               = awReady_r;
    assign wready                = wReady_r;
    assign bvalid                = bvalid_r;
    assign bresp                 = section_crc_pkg::AXI_OKAY;
    assign arready               = arReady_r;
    assign rvalid                = rvalid_r;
    assign rdata                 = rdata_r;
    assign rresp                 = section_crc_pkg::AXI_OKAY;
    assign sectionCrcFaultN      = faultN_r;
    assign digitalCombinedFaultN = combN_r;
    assign irq                   = irq_r;

    assign doWrite = awFull_r && wFull_r && !bvalid_r;

    // axi handshakes: address and data taken in either order
    always_comb begin
        awFull_nxt = awFull_r;
        wFull_nxt  = wFull_r;
        wrIdx_nxt  = wrIdx_r;
        wrData_nxt = wrData_r;
        wrStrb_nxt = wrStrb_r;
        bvalid_nxt = bvalid_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        if (awvalid && awReady_r) begin
            awFull_nxt = 1'b1;
            wrIdx_nxt  = awaddr[9:2];
        end
        if (wvalid && wReady_r) begin
            wFull_nxt  = 1'b1;
            wrData_nxt = wdata[15:0];
            wrStrb_nxt = wstrb[1:0];
        end
        if (doWrite) begin
            awFull_nxt = 1'b0;
            wFull_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
        end else if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end
        if (arvalid && arReady_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = 32'h00000000;
            case (araddr[9:2])
                section_crc_pkg::IDX_CRC_CTRL:
                    rdata_nxt = {28'h0000000, polySel_r, enable_r};
                section_crc_pkg::IDX_CRC_EXP1:
                    rdata_nxt = {16'h0000, expected_r[0]};
                section_crc_pkg::IDX_CRC_EXP2:
                    rdata_nxt = {16'h0000, expected_r[1]};
                section_crc_pkg::IDX_CRC_EXP3:
                    rdata_nxt = {16'h0000, expected_r[2]};
                section_crc_pkg::IDX_DIG_STATUS:
                    rdata_nxt = {29'h00000000, faultN_r};
                section_crc_pkg::IDX_COMB_STATUS:
                    rdata_nxt = {31'h00000000, combN_r};
                section_crc_pkg::IDX_DIG_MASK:
                    rdata_nxt = {29'h00000000, mask_r};
                section_crc_pkg::IDX_INT_STATUS:
                    rdata_nxt = {29'h00000000, intStat_r};
                section_crc_pkg::IDX_INT_MASK:
                    rdata_nxt = {29'h00000000, intMask_r};
                default: begin
                    // section zero and unlisted indices read as zero
                    if (inSection(araddr[9:2])) begin
                        rdata_nxt = {16'h0000, mapMem_r[araddr[9:2]]};
                    end
                end
            endcase
        end else if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end
        awReady_nxt = !awFull_nxt && !bvalid_nxt;
        wReady_nxt  = !wFull_nxt && !bvalid_nxt;
        arReady_nxt = !rvalid_nxt;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            awFull_r  <= 1'b0;
            wFull_r   <= 1'b0;
            awReady_r <= 1'b0;
            wReady_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            arReady_r <= 1'b0;
            rvalid_r  <= 1'b0;
            wrIdx_r   <= 8'h00;
            wrData_r  <= 16'h0000;
            wrStrb_r  <= 2'h0;
            rdata_r   <= 32'h00000000;
        end else begin
            awFull_r  <= awFull_nxt;
            wFull_r   <= wFull_nxt;
            awReady_r <= awReady_nxt;
            wReady_r  <= wReady_nxt;
            bvalid_r  <= bvalid_nxt;
            arReady_r <= arReady_nxt;
            rvalid_r  <= rvalid_nxt;
            wrIdx_r   <= wrIdx_nxt;
            wrData_r  <= wrData_nxt;
            wrStrb_r  <= wrStrb_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // register writes, sticky flags and interrupt
    always_comb begin
        logic clrHit;
        logic allClear;
        clrHit       = 1'b0;
        allClear     = 1'b0;
        mapMem_nxt   = mapMem_r;
        enable_nxt   = enable_r;
        polySel_nxt  = polySel_r;
        expected_nxt = expected_r;
        faultN_nxt   = faultN_r;
        combN_nxt    = combN_r;
        mask_nxt     = mask_r;
        intStat_nxt  = intStat_r;
        intMask_nxt  = intMask_r;
        if (doWrite && wrStrb_r[0]) begin
            case (wrIdx_r)
                section_crc_pkg::IDX_CRC_CTRL: begin
                    enable_nxt  = wrData_r[section_crc_pkg::CTRL_EN_LSB +: 3];
                    polySel_nxt = wrData_r[section_crc_pkg::CTRL_POLY_BIT];
                end
                section_crc_pkg::IDX_DIG_STATUS: begin
                    faultN_nxt = faultN_r |
                        wrData_r[section_crc_pkg::FAULT_LSB +: 3];
                end
                section_crc_pkg::IDX_COMB_STATUS:
                    clrHit = wrData_r[section_crc_pkg::COMB_FAULT_BIT];
                section_crc_pkg::IDX_DIG_MASK:
                    mask_nxt = wrData_r[2:0];
                section_crc_pkg::IDX_INT_STATUS:
                    intStat_nxt = intStat_r & ~wrData_r[2:0];
                section_crc_pkg::IDX_INT_MASK:
                    intMask_nxt = wrData_r[2:0];
                default: begin
                end
            endcase
        end
        if (doWrite) begin
            for (int s = 0; s < section_crc_pkg::NUM_SECTIONS; s++) begin
                if (wrIdx_r == section_crc_pkg::IDX_CRC_EXP1 + 8'(s)) begin
                    expected_nxt[s] = strobed(expected_r[s], wrData_r,
                                              wrStrb_r);
                end
            end
            if (inSection(wrIdx_r)) begin
                mapMem_nxt[wrIdx_r] = strobed(mapMem_r[wrIdx_r], wrData_r,
                                              wrStrb_r);
            end
        end
        // a mismatch in the clearing cycle still lands: set beats clear
        faultN_nxt  = faultN_nxt & ~mismatch;
        intStat_nxt = intStat_nxt | mismatch;
        // all detail flags must already read one before the write
        allClear = &faultN_r;
        if (clrHit && allClear) begin
            combN_nxt = 1'b1;
        end
        if (|(~faultN_nxt & ~mask_nxt)) begin
            combN_nxt = 1'b0;
        end
        irq_nxt = |(intStat_nxt & intMask_nxt);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < 256; k++) begin
                mapMem_r[k] <= section_crc_pkg::RST_MAP_WORD;
            end
            enable_r   <= section_crc_pkg::RST_ENABLE;
            polySel_r  <= section_crc_pkg::RST_POLY;
            expected_r <= {3{section_crc_pkg::RST_EXPECTED}};
            faultN_r   <= section_crc_pkg::RST_FAULT_N;
            combN_r    <= section_crc_pkg::RST_COMB_N;
            mask_r     <= section_crc_pkg::RST_MASK;
            intStat_r  <= section_crc_pkg::RST_INT;
            intMask_r  <= section_crc_pkg::RST_INT;
            irq_r      <= 1'b0;
        end else begin
            mapMem_r   <= mapMem_nxt;
            enable_r   <= enable_nxt;
            polySel_r  <= polySel_nxt;
            expected_r <= expected_nxt;
            faultN_r   <= faultN_nxt;
            combN_r    <= combN_nxt;
            mask_r     <= mask_nxt;
            intStat_r  <= intStat_nxt;
            intMask_r  <= intMask_nxt;
            irq_r      <= irq_nxt;
        end
    end

    // diagnostic oscillator period as a one-cycle enable
    always_comb begin
        tick_nxt   = 1'b0;
        divCnt_nxt = divCnt_r + 8'h01;
        if (divCnt_r == section_crc_pkg::DIAG_OSC_DIV - 8'h01) begin
            divCnt_nxt = 8'h00;
            tick_nxt   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            divCnt_r <= 8'h00;
            tick_r   <= 1'b0;
        end else begin
            divCnt_r <= divCnt_nxt;
            tick_r   <= tick_nxt;
        end
    end

    assign poly = polySel_r ? section_crc_pkg::CRC_POLY_ANSI
                            : section_crc_pkg::CRC_POLY_CCITT;

    // one serial engine per configuration section; section zero has none
    for (genvar i = 0; i < section_crc_pkg::NUM_SECTIONS; i++) begin : g_eng
        always_comb begin
            logic        din;
            logic [15:0] step;
            din         = mapMem_r[ptr_r[i]][bit_r[i]];
            step        = {crc_r[i][14:0], 1'b0} ^
                          ((crc_r[i][15] ^ din) ? poly : 16'h0000);
            ptr_nxt[i]  = ptr_r[i];
            bit_nxt[i]  = bit_r[i];
            crc_nxt[i]  = crc_r[i];
            mismatch[i] = 1'b0;
            if (!enable_r[i]) begin
                // held at the start so re-enabling runs a fresh pass
                ptr_nxt[i] = section_crc_pkg::SEC_FIRST[i];
                bit_nxt[i] = section_crc_pkg::MSB_BIT;
                crc_nxt[i] = section_crc_pkg::CRC_SEED;
            end else if (tick_r) begin
                if (ptr_r[i] == section_crc_pkg::SEC_LAST[i] &&
                    bit_r[i] == section_crc_pkg::LSB_BIT) begin
                    mismatch[i] = (step != expected_r[i]);
                    ptr_nxt[i]  = section_crc_pkg::SEC_FIRST[i];
                    bit_nxt[i]  = section_crc_pkg::MSB_BIT;
                    crc_nxt[i]  = section_crc_pkg::CRC_SEED;
                end else begin
                    crc_nxt[i] = step;
                    if (bit_r[i] == section_crc_pkg::LSB_BIT) begin
                        bit_nxt[i] = section_crc_pkg::MSB_BIT;
                        ptr_nxt[i] = ptr_r[i] + 8'h01;
                    end else begin
                        bit_nxt[i] = bit_r[i] - 4'h1;
                    end
                end
            end
        end

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                ptr_r[i] <= section_crc_pkg::SEC_FIRST[i];
                bit_r[i] <= section_crc_pkg::MSB_BIT;
                crc_r[i] <= section_crc_pkg::CRC_SEED;
            end else begin
                ptr_r[i] <= ptr_nxt[i];
                bit_r[i] <= bit_nxt[i];
                crc_r[i] <= crc_nxt[i];
            end
        end
    end

endmodule
